// *** logic/sensor_spi_pkg.sv ***
// Shared constants of the sensor serial slave and its diagnostic flags.
// Assumes a 40 MHz system clock and a master clocking the link at up to 8 MHz.
package sensor_spi_pkg;
  // Frame geometry, counted in link clock rising edges
  localparam int          BYTE_W     = 8;
  localparam int          WORD_W     = 16;
  localparam logic [5:0]  CMD_END    = 6'h08;
  localparam logic [5:0]  RW_END     = 6'h18;
  localparam logic [5:0]  QR_END     = 6'h28;
  localparam logic [5:0]  CNT_MAX    = 6'h29;
  localparam int          DIR_BIT    = 4;
  localparam logic [7:0]  DIR_MASK   = 8'h10;

  // Command codes (read codes; write codes have the direction bit set)
  localparam logic [7:0]  CMD_QUICK  = 8'h90;
  localparam logic [7:0]  A_ID       = 8'h01;
  localparam logic [7:0]  A_STATUS   = 8'h02;
  localparam logic [7:0]  A_IDATA    = 8'h03;
  localparam logic [7:0]  A_QDATA    = 8'h04;
  localparam logic [7:0]  A_ADCST    = 8'h05;
  localparam logic [7:0]  A_MODE     = 8'h23;
  localparam logic [7:0]  A_CONV     = 8'h2A;
  localparam logic [7:0]  A_BLANK    = 8'h2B;
  localparam logic [7:0]  A_ROUTE    = 8'h2C;

  // Reset values
  localparam logic [15:0] RST_ZERO   = 16'h0000;
  localparam logic [15:0] RST_BLANK  = 16'h003F;
  localparam logic [15:0] RST_ROUTE  = 16'h00FF;
  localparam logic [7:0]  RST_CMD    = 8'h00;

  // Blanking counter width and status bit positions
  localparam int          BLANK_W    = 6;
  localparam int          ST_CBF     = 0;
  localparam int          ST_PPS     = 1;
  localparam int          ST_DIAG    = 2;

  // Link timing figures in ns and the system clock period
  localparam int          CLK_NS     = 25;
  localparam int          T_SCK_NS   = 125;
  localparam int          SCK_CYC    = (T_SCK_NS + CLK_NS - 1) / CLK_NS;
endpackage

// *** logic/diag_blank_counter.sv ***
// Up/down maturity counter that blanks one diagnostic.
// Assumes tick is a one-cycle pulse per transmitter sine period.
module diag_blank_counter #(
  parameter int W = sensor_spi_pkg::BLANK_W
) (
  input  wire logic         clk,    // System clock
  input  wire logic         rst_n,  // Synchronous reset, active low
  input  wire logic         tick,   // One pulse per sine period
  input  wire logic         fault,  // Synchronised raw fault level
  input  wire logic [W-1:0] limit,  // Maturity threshold
  output logic              mature  // Pulse when fault has matured
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Step only on the sine tick, so each fault is judged once per period
  always_comb begin
    cnt_nxt = cnt_r;
    if (tick && fault && cnt_r < limit) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (tick && !fault && cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Own counter per diagnostic; it never sees another diagnostic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Maturity pulse once the counter sits at the threshold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mature <= 1'b0;
    end else begin
      mature <= tick && fault && cnt_nxt >= limit;
    end
  end

  a_blank_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !tick |=> $stable(cnt_r))
    else $error("blanking counter moved without a sine tick");
endmodule

// *** logic/sensor_spi_slave.sv ***
// Serial slave of the impedance sensor: command frames, register file,
// I/Q result hand-off and blanked, latched diagnostic status flags.
// Assumes the master's link clock stands still outside frames and that
// chip select stays high for a whole command sequence.
// Functional notes
// - Chip select high selects the device for the whole command sequence.
// - Data output is high impedance whenever chip select is low.
// - Input sampled on rising link edge, output changed on falling edge.
// - Link clock may idle high or low; both work.
// - Bytes are eight bits, MSB first; words go high byte first.
// - Missing write data bits are filled with zeros.
// - Write returns command echo, then zeros, then zero on extra clocks.
// - Read is three bytes: echo, register high byte, low byte.
// - After the last read byte, the last data bit keeps being driven.
// - Quick read is 40 bits: command, I word, Q word.
// - I and Q of one quick read come from one matched sample.
// - I and Q results clear to zero once read.
// - Command bit 4 is direction: zero read, one write, except the quick read code, which is a read.
// - Identification read always returns the fixed identity code.
// - Each blanked diagnostic has its own up/down maturity counter.
// - Blanking counters step once per transmitter sine period.
// - Blanked flags stay set until the status register is read.
// - Blanking configuration read returns its current value.
// - Current buffer fail flag rises when buffer output leaves thresholds.
// - Short flag rises when the selected pin pair resistance is low.
// - Converter mode comes from the conversion control register.
module sensor_spi_slave #(
  parameter logic [15:0] ID_CODE = 16'h5A5A, // Arbitrary identity value
  parameter int          N_DIAG  = 7         // Further blanked diagnostics
) (
  input  wire logic              clk,           // System clock, 40 MHz
  input  wire logic              rst_n,         // Synchronous reset
  input  wire logic              sclk,          // Link clock from master
  input  wire logic              cs,            // Chip select, active high
  input  wire logic              mosi,          // Serial data in
  output logic                   miso_o,        // Serial data out value
  output logic                   miso_oe_n,     // Low while driving
  input  wire logic              sine_ref,      // Transmitter sine square
  input  wire logic              buf_low,       // Buffer below low limit
  input  wire logic              buf_high,      // Buffer above high limit
  input  wire logic              pin_short_cmp, // Pair resistance too low
  input  wire logic [N_DIAG-1:0] diag_fault,    // Other raw faults
  input  wire logic              sample_valid,  // Matched I/Q pair ready
  input  wire logic [15:0]       sample_i,      // I result
  input  wire logic [15:0]       sample_q,      // Q result
  input  wire logic [15:0]       adc_status,    // Converter status word
  output logic [15:0]            sensor_mode,   // Main multiplexer setting
  output logic [15:0]            conv_ctl,      // Conversion control
  output logic [15:0]            blank_cfg,     // Blanking threshold
  output logic [15:0]            route_sel,     // Short test routing
  output logic [N_DIAG+1:0]      status         // Latched status flags
);
  localparam int ST_W = N_DIAG + 2;

  // Link domain state
  logic        started_r;
  logic [5:0]  rise_cnt_r;
  logic [5:0]  rise_nxt;
  logic [5:0]  idx_r;
  logic [7:0]  cmd_r;
  logic [15:0] data_r;
  logic [15:0] rd_word;
  logic        miso_bit;
  logic [31:0] iq_word;

  // System domain state
  logic        cs_s1_r;
  logic        cs_s2_r;
  logic        cs_s3_r;
  logic        frame_end;
  logic [2:0]  sine_s_r;
  logic        tick;
  logic [1:0]  buf_lo_s_r;
  logic [1:0]  buf_hi_s_r;
  logic [1:0]  pps_s_r;
  logic [N_DIAG-1:0] diag_s1_r;
  logic [N_DIAG-1:0] diag_s2_r;
  logic [ST_W-1:0]   raw;
  logic [ST_W-1:0]   mature;
  logic [ST_W-1:0]   status_r;
  logic [15:0] i_r;
  logic [15:0] q_r;
  logic [15:0] snap_i_r;
  logic [15:0] snap_q_r;
  logic [15:0] snap_st_r;
  logic [15:0] snap_adc_r;
  logic [7:0]  echo_r;
  logic [7:0]  rd_addr;
  logic        is_wr;
  logic        rd_done;
  logic        qr_done;
  logic        wr_ok;
  logic        st_clr;
  logic        i_clr;
  logic        q_clr;

  // Count of rising edges in this frame; the first edge restarts it
  assign rise_nxt = started_r ? rise_cnt_r + 6'h01 : 6'h01;

  // Frame start marker, dropped the moment chip select falls
  always_ff @(posedge sclk or negedge cs) begin
    if (!cs) begin
      started_r <= 1'b0;
    end else begin
      started_r <= 1'b1;
    end
  end

  // Edge counter saturates so endless clocking cannot wrap it
  always_ff @(posedge sclk) begin
    if (rise_nxt <= sensor_spi_pkg::CNT_MAX) begin
      rise_cnt_r <= rise_nxt;
    end
  end

  // Command byte shifted in MSB first on rising edges
  always_ff @(posedge sclk) begin
    if (rise_nxt <= sensor_spi_pkg::CMD_END) begin
      cmd_r <= {cmd_r[6:0], mosi};
    end
  end

  // Write data: cleared at frame start so missing bits read as zero
  always_ff @(posedge sclk) begin
    if (!started_r) begin
      data_r <= sensor_spi_pkg::RST_ZERO;
    end else if (rise_nxt > sensor_spi_pkg::CMD_END &&
                 rise_nxt <= sensor_spi_pkg::RW_END) begin
      data_r[4'(sensor_spi_pkg::RW_END - rise_nxt)] <= mosi;
    end
  end

  // Output bit index follows on falling edges; a leading fall on an
  // idle-high clock leaves it at zero, so both idle levels work
  always_ff @(negedge sclk or negedge cs) begin
    if (!cs) begin
      idx_r <= 6'h00;
    end else begin
      idx_r <= started_r ? rise_cnt_r : 6'h00;
    end
  end

  // Register read mux; every source is held still while selected
  always_comb begin
    case (cmd_r)
      sensor_spi_pkg::A_ID:     rd_word = ID_CODE;
      sensor_spi_pkg::A_STATUS: rd_word = snap_st_r;
      sensor_spi_pkg::A_IDATA:  rd_word = snap_i_r;
      sensor_spi_pkg::A_QDATA:  rd_word = snap_q_r;
      sensor_spi_pkg::A_ADCST:  rd_word = snap_adc_r;
      sensor_spi_pkg::A_MODE:   rd_word = sensor_mode;
      sensor_spi_pkg::A_CONV:   rd_word = conv_ctl;
      sensor_spi_pkg::A_BLANK:  rd_word = blank_cfg;
      sensor_spi_pkg::A_ROUTE:  rd_word = route_sel;
      default:                  rd_word = sensor_spi_pkg::RST_ZERO;
    endcase
  end

  // Quick read shifts I then Q as one 32-bit word
  assign iq_word = {snap_i_r, snap_q_r};

  // Serial bit selection: echo, then data MSB first, then hold or zero;
  // quick read goes first because its code carries the direction bit
  always_comb begin
    if (idx_r < sensor_spi_pkg::CMD_END) begin
      miso_bit = echo_r[3'(sensor_spi_pkg::BYTE_W - 1 - idx_r)];
    end else if (cmd_r == sensor_spi_pkg::CMD_QUICK) begin
      if (idx_r < sensor_spi_pkg::QR_END) begin
        miso_bit = iq_word[5'(sensor_spi_pkg::QR_END - 6'h01 - idx_r)];
      end else begin
        miso_bit = snap_q_r[0];
      end
    end else if (is_wr) begin
      miso_bit = 1'b0;
    end else if (idx_r < sensor_spi_pkg::RW_END) begin
      miso_bit = rd_word[4'(sensor_spi_pkg::RW_END - 6'h01 - idx_r)];
    end else begin
      miso_bit = rd_word[0];
    end
  end

  // Pin drive: released whenever chip select is low
  assign miso_o    = cs ? miso_bit : 1'b0;
  assign miso_oe_n = !cs;

  // Chip select crossing; the third stage feeds edge detect and snapshot gate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_s1_r <= 1'b0;
      cs_s2_r <= 1'b0;
      cs_s3_r <= 1'b0;
    end else begin
      cs_s1_r <= cs;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
    end
  end
  assign frame_end = cs_s3_r && !cs_s2_r;

  // Frame outcome; link registers are still once chip select is low
  assign rd_addr = cmd_r & ~sensor_spi_pkg::DIR_MASK;
  assign is_wr   = cmd_r[sensor_spi_pkg::DIR_BIT] &&
                   cmd_r != sensor_spi_pkg::CMD_QUICK;
  assign wr_ok   = frame_end && is_wr && rise_cnt_r > sensor_spi_pkg::CMD_END;
  assign rd_done = frame_end && !is_wr && rise_cnt_r >= sensor_spi_pkg::RW_END;
  assign qr_done = rd_done && cmd_r == sensor_spi_pkg::CMD_QUICK &&
                   rise_cnt_r >= sensor_spi_pkg::QR_END;
  assign st_clr  = rd_done && cmd_r == sensor_spi_pkg::A_STATUS;
  assign i_clr   = qr_done || (rd_done && cmd_r == sensor_spi_pkg::A_IDATA);
  assign q_clr   = qr_done || (rd_done && cmd_r == sensor_spi_pkg::A_QDATA);

  // Echo of the last complete command byte, taken at frame end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      echo_r <= sensor_spi_pkg::RST_CMD;
    end else if (frame_end && rise_cnt_r >= sensor_spi_pkg::CMD_END) begin
      echo_r <= cmd_r;
    end
  end

  // Configuration writes land between frames so reads stay coherent
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sensor_mode <= sensor_spi_pkg::RST_ZERO;
      conv_ctl    <= sensor_spi_pkg::RST_ZERO;
      blank_cfg   <= sensor_spi_pkg::RST_BLANK;
      route_sel   <= sensor_spi_pkg::RST_ROUTE;
    end else if (wr_ok) begin
      case (rd_addr)
        sensor_spi_pkg::A_MODE:  sensor_mode <= data_r;
        sensor_spi_pkg::A_CONV:  conv_ctl    <= data_r;
        sensor_spi_pkg::A_BLANK: blank_cfg   <= data_r;
        sensor_spi_pkg::A_ROUTE: route_sel   <= data_r;
        default:                 ;
      endcase
    end
  end

  // Analog levels cross with two flops each
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sine_s_r   <= 3'h0;
      buf_lo_s_r <= 2'h0;
      buf_hi_s_r <= 2'h0;
      pps_s_r    <= 2'h0;
      diag_s1_r  <= '0;
      diag_s2_r  <= '0;
    end else begin
      sine_s_r   <= {sine_s_r[1:0], sine_ref};
      buf_lo_s_r <= {buf_lo_s_r[0], buf_low};
      buf_hi_s_r <= {buf_hi_s_r[0], buf_high};
      pps_s_r    <= {pps_s_r[0], pin_short_cmp};
      diag_s1_r  <= diag_fault;
      diag_s2_r  <= diag_s1_r;
    end
  end
  assign tick = sine_s_r[1] && !sine_s_r[2];

  // Raw fault vector in status order
  assign raw[sensor_spi_pkg::ST_CBF]         = buf_lo_s_r[1] || buf_hi_s_r[1];
  assign raw[sensor_spi_pkg::ST_PPS]         = pps_s_r[1];
  assign raw[ST_W-1:sensor_spi_pkg::ST_DIAG] = diag_s2_r;

  // One blanking counter per diagnostic; the short test needs none
  genvar g;
  generate
    for (g = 0; g < ST_W; g++) begin : g_diag
      if (g == sensor_spi_pkg::ST_PPS) begin : g_direct
        assign mature[g] = raw[g];
      end else begin : g_blank
        diag_blank_counter #(
          .W(sensor_spi_pkg::BLANK_W)
        ) u_cnt (
          .clk   (clk),
          .rst_n (rst_n),
          .tick  (tick),
          .fault (raw[g]),
          .limit (blank_cfg[sensor_spi_pkg::BLANK_W-1:0]),
          .mature(mature[g])
        );
      end
    end
  endgenerate

  // Sticky flags: a new maturity wins over a clearing read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_r <= '0;
    end else begin
      status_r <= (st_clr ? '0 : status_r) | mature;
    end
  end
  assign status = status_r;

  // Result pair: a fresh sample wins over the clear after a read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      i_r <= sensor_spi_pkg::RST_ZERO;
      q_r <= sensor_spi_pkg::RST_ZERO;
    end else if (sample_valid) begin
      i_r <= sample_i;
      q_r <= sample_q;
    end else begin
      if (i_clr) begin
        i_r <= sensor_spi_pkg::RST_ZERO;
      end
      if (q_clr) begin
        q_r <= sensor_spi_pkg::RST_ZERO;
      end
    end
  end

  // Snapshots freeze while selected, so a frame never sees a half update
  // and I/Q always belong together; costs one clock of latency
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snap_i_r   <= sensor_spi_pkg::RST_ZERO;
      snap_q_r   <= sensor_spi_pkg::RST_ZERO;
      snap_st_r  <= sensor_spi_pkg::RST_ZERO;
      snap_adc_r <= sensor_spi_pkg::RST_ZERO;
    end else if (!cs_s2_r && !cs_s3_r) begin
      snap_i_r   <= i_r;
      snap_q_r   <= q_r;
      snap_st_r  <= 16'(status_r);
      snap_adc_r <= adc_status;
    end
  end

  sequence s_frame_end;
    cs_s3_r && !cs_s2_r;
  endsequence

  a_write_zero: assert property (@(posedge sclk) disable iff (!cs)
    started_r && is_wr && idx_r >= sensor_spi_pkg::CMD_END |-> !miso_o)
    else $error("write frame returned a one after the echo");
  a_read_hold: assert property (@(posedge sclk) disable iff (!cs)
    started_r && !is_wr && cmd_r != sensor_spi_pkg::CMD_QUICK &&
    idx_r > sensor_spi_pkg::RW_END |-> miso_o == rd_word[0])
    else $error("read tail did not hold the last data bit");
  a_id_word: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_r == sensor_spi_pkg::A_ID |-> rd_word == ID_CODE)
    else $error("identity read gave another word");
  a_status_stick: assert property (@(posedge clk) disable iff (!rst_n)
    status_r[sensor_spi_pkg::ST_CBF] && !st_clr |=> status_r[sensor_spi_pkg::ST_CBF])
    else $error("latched buffer fail flag dropped without a read");
  a_status_clear: assert property (@(posedge clk) disable iff (!rst_n)
    s_frame_end ##0 (st_clr && mature == '0) |=> status_r == '0)
    else $error("status read did not clear the flags");
  a_iq_clear: assert property (@(posedge clk) disable iff (!rst_n)
    qr_done && !sample_valid |=> i_r == 16'h0000 && q_r == 16'h0000)
    else $error("quick read left a result standing");
  a_iq_pair: assert property (@(posedge clk) disable iff (!rst_n)
    cs_s2_r && cs_s3_r |=> $stable(snap_i_r) && $stable(snap_q_r))
    else $error("result snapshot changed inside a frame");
  a_blank_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ok && rd_addr == sensor_spi_pkg::A_BLANK |=> blank_cfg == $past(data_r))
    else $error("blanking write not applied");
  a_cbf_raise: assert property (@(posedge clk) disable iff (!rst_n)
    mature[sensor_spi_pkg::ST_CBF] |=> status_r[sensor_spi_pkg::ST_CBF])
    else $error("matured buffer fail did not set its flag");
  a_hiz_off: assert property (@(posedge clk) disable iff (!rst_n)
    !cs |-> miso_oe_n && !miso_o)
    else $error("data out driven while deselected");
endmodule

// *** verification/spi_master_model.sv ***
// Master side of the serial link: frames bits and samples the answer.
// Assumes the bench picks idle_hi between frames and calls xfer.
module spi_master_model (
  output logic      sclk, // Link clock, still outside frames
  output logic      cs,   // Chip select, active high
  output logic      mosi, // Serial data to the device
  input  wire logic miso  // Resolved serial data line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic idle_hi;

  // Clock and data rest low at start, like the pull-downs on the device pins
  initial begin
    sclk = 1'b0;
    cs = 1'b1;
    mosi = 1'b0;
    idle_hi = 1'b0;
    // A brief select gives the frame logic a clean falling edge to clear on
    #5 cs = 1'b0;
  end

  // One frame of n bits taken from tx[n-1] downwards; reply shifts into rx
  task automatic xfer(input int n, input logic [47:0] tx, output logic [47:0] rx);
    rx = 48'h0;
    sclk = idle_hi;
    #23.7 cs = 1'b1; // Held for the whole frame
    #20;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0; // Outgoing bit changes on the fall
      mosi = tx[i]; // MSB first, zeros after a read command
      #62.5 sclk = 1'b1;
      rx = {rx[46:0], miso}; // Taken on the rise
      #62.5;
    end
    sclk = idle_hi;
    #15 cs = 1'b0;
    mosi = 1'b0;
  endtask
endmodule

// *** verification/sensor_spi_slave_tb.sv ***
// Self-checking bench of the sensor serial slave and its blanked flags.
// Assumes spi_master_model drives the link; miso has a weak pull-down.
module sensor_spi_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] ID_V = 16'h3C96; // Arbitrary identity value
  logic        clk = 1'b0, rst_n = 1'b0, sine_ref = 1'b0, sample_valid = 1'b0;
  logic        buf_low = 1'b0, buf_high = 1'b0, pin_short_cmp = 1'b0;
  logic [6:0]  diag_fault = 7'h00;
  logic [15:0] sample_i = 16'h0000, sample_q = 16'h0000, adc_status = 16'h0000;
  logic [15:0] sensor_mode, conv_ctl, blank_cfg, route_sel, d, q;
  logic [8:0]  status;
  logic        sclk, cs, mosi, miso_o, miso_oe_n;
  logic [47:0] rx;
  logic [7:0]  last_cmd = 8'h00, e;
  logic [7:0]  ra [4] = '{8'h23, 8'h2A, 8'h2B, 8'h2C};
  logic [15:0] mreg [logic [7:0]];
  logic [31:0] seed = 32'h0000000A;
  int          n_fail = 0, tests_run = 0;
  // Released line falls to the weak pull-down
  wire         miso_w = miso_oe_n ? 1'b0 : miso_o;

  always #12.5 clk = ~clk;

  // Sine square: one blanking tick every 20 clocks
  always begin
    repeat (10) @(posedge clk);
    #2 sine_ref = ~sine_ref;
  end

  spi_master_model mst_u (.sclk(sclk), .cs(cs), .mosi(mosi), .miso(miso_w));

  sensor_spi_slave #(.ID_CODE(ID_V), .N_DIAG(7)) dut_u (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs(cs), .mosi(mosi),
    .miso_o(miso_o), .miso_oe_n(miso_oe_n), .sine_ref(sine_ref),
    .buf_low(buf_low), .buf_high(buf_high), .pin_short_cmp(pin_short_cmp),
    .diag_fault(diag_fault), .sample_valid(sample_valid), .sample_i(sample_i),
    .sample_q(sample_q), .adc_status(adc_status), .sensor_mode(sensor_mode),
    .conv_ctl(conv_ctl), .blank_cfg(blank_cfg), .route_sel(route_sel),
    .status(status));

  function automatic logic [15:0] rnd16();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Echo is the last whole command of the frame before
  task automatic frame(input int n, input logic [47:0] tx);
    e = last_cmd;
    mst_u.xfer(n, tx, rx);
    if (n >= 8) last_cmd = tx[n-1 -: 8];
    wait_clk(8);
    chk("oe", {63'h0, miso_oe_n}, 64'h1);
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] v);
    frame(26, {22'h0, c, 18'h0});
    chk("read", rx[25:0], {e, v, v[0], v[0]});
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    frame(26, {22'h0, c | 8'h10, v, 2'b00});
    mreg[c] = v;
    chk("write", rx[25:0], {e, 18'h0});
    chk("regs", {sensor_mode, conv_ctl, blank_cfg, route_sel},
        {mreg[8'h23], mreg[8'h2A], mreg[8'h2B], mreg[8'h2C]});
  endtask

  task automatic qr(input logic [15:0] i, input logic [15:0] qv);
    frame(42, {6'h0, 8'h90, 34'h0});
    chk("quick", rx[41:0], {e, i, qv, qv[0], qv[0]});
  endtask

  task automatic samp(input logic [15:0] i, input logic [15:0] qv);
    @(posedge clk);
    #2 sample_valid = 1'b1;
    sample_i = i;
    sample_q = qv;
    wait_clk(1);
    sample_valid = 1'b0;
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hang is cut short well past the expected run length
  initial begin
    #1500000;
    n_fail++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    mreg[8'h23] = 16'h0000;
    mreg[8'h2A] = 16'h0000;
    mreg[8'h2B] = 16'h003F;
    mreg[8'h2C] = 16'h00FF;
    wait_clk(20);
    rst_n = 1'b1;
    wait_clk(4);
    rd(8'h01, ID_V);
    foreach (ra[k]) rd(ra[k], mreg[ra[k]]);
    for (int m = 0; m < 2; m++) begin
      mst_u.idle_hi = m[0];
      foreach (ra[k]) begin
        d = rnd16();
        wr(ra[k], d);
        rd(ra[k], d);
      end
      rd(8'h01, ID_V);
    end
    mst_u.idle_hi = 1'b0;
    // Write cut after four data bits, then a frame dropped mid-command
    frame(12, {36'h0, 8'h3B, 4'hA});
    mreg[8'h2B] = 16'hA000;
    chk("pad", {48'h0, blank_cfg}, 64'hA000);
    frame(5, 48'h0);
    rd(8'h2B, 16'hA000);
    adc_status = rnd16();
    wait_clk(8);
    rd(8'h05, adc_status);
    // A new pair arriving mid-frame must not tear the quick read
    d = rnd16();
    q = rnd16();
    samp(d, q);
    wait_clk(4);
    fork
      qr(d, q);
      begin
        #1500;
        samp(~d, ~q);
      end
    join
    samp(q, d);
    wait_clk(4);
    rd(8'h03, q);
    rd(8'h03, 16'h0000);
    rd(8'h04, d);
    rd(8'h04, 16'h0000);
    samp(d, q);
    wait_clk(4);
    qr(d, q);
    rd(8'h03, 16'h0000);
    rd(8'h04, 16'h0000);
    // Blanking with a limit of three ticks
    wr(8'h2B, 16'h0003);
    buf_high = 1'b1;
    wait_clk(5);
    buf_high = 1'b0;
    wait_clk(100);
    chk("glitch", {55'h0, status}, 64'h0);
    // A second diagnostic faults for two ticks only and must stay clear
    buf_low = 1'b1;
    diag_fault = 7'h01;
    wait_clk(40);
    diag_fault = 7'h00;
    chk("early", {63'h0, status[0]}, 64'h0);
    wait_clk(160);
    chk("set", {63'h0, status[0]}, 64'h1);
    chk("indep", {63'h0, status[2]}, 64'h0);
    buf_low = 1'b0;
    wait_clk(200);
    chk("held", {63'h0, status[0]}, 64'h1);
    wr(8'h23, 16'h0000);
    wr(8'h2C, rnd16());
    pin_short_cmp = 1'b1;
    wait_clk(5);
    pin_short_cmp = 1'b0;
    wait_clk(10);
    rd(8'h02, 16'h0003);
    chk("clear", {55'h0, status}, 64'h0);
    report_and_stop();
  end
endmodule
